//--- src/irq_regs_pkg.sv
// Constants shared by the interrupt flag and enable register files.
package irq_regs_pkg;

  // ********************************************************************
  // Bus and register layout
  // ********************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] FLAG4_IDX = 4'h0;
  localparam logic [ADDR_W-1:0] ENABLE0_IDX = 4'h1;
  localparam logic [DATA_W-1:0] FLAG4_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ENABLE0_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] FLAG4_IMPL = 16'hCE7E;
  localparam logic [DATA_W-1:0] ENABLE0_IMPL = 16'h7FFF;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  // ********************************************************************
  // Field positions of flag_status_4
  // ********************************************************************
  localparam int AUDIO_LEFT_BIT = 15;
  localparam int AUDIO_RIGHT_BIT = 14;
  localparam int ENCODER_B_BIT = 11;
  localparam int PWM_B_FAULT_BIT = 10;
  localparam int PWM_B_EVENT_BIT = 9;
  localparam int CAN_TX_BIT = 6;
  localparam int DMA_CH7_BIT = 5;
  localparam int DMA_CH6_BIT = 4;
  localparam int CHECKSUM_GEN_BIT = 3;
  localparam int SERIAL_B_ERR_BIT = 2;
  localparam int SERIAL_A_ERR_BIT = 1;

  // ********************************************************************
  // Field positions of interrupt_enable_0
  // ********************************************************************
  localparam int DMA_CH1_EN_BIT = 14;
  localparam int ADC_EN_BIT = 13;
  localparam int SERIAL_A_TX_EN_BIT = 12;
  localparam int SERIAL_A_RX_EN_BIT = 11;
  localparam int SPI_A_EVENT_EN_BIT = 10;
  localparam int SPI_A_ERROR_EN_BIT = 9;
  localparam int TIMER_THREE_EN_BIT = 8;
  localparam int TIMER_TWO_EN_BIT = 7;
  localparam int COMPARE_CH2_EN_BIT = 6;
  localparam int CAPTURE_CH2_EN_BIT = 5;
  localparam int DMA_CH0_EN_BIT = 4;
  localparam int TIMER_ONE_EN_BIT = 3;
  localparam int COMPARE_CH1_EN_BIT = 2;
  localparam int CAPTURE_CH1_EN_BIT = 1;
  localparam int EXT_PIN0_EN_BIT = 0;

endpackage : irq_regs_pkg

//--- src/irq_bit_bank.sv
// One software-writable register of sticky bits with hardware set inputs.
`timescale 1ns/10ps
`default_nettype none
module irq_bit_bank #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL = '1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [WIDTH-1:0] set_i,
  output logic [WIDTH-1:0] value_o
);

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } bank_type;

  bank_type state_reg;
  bank_type state_next;

  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("irq_bit_bank: WIDTH must lie between 1 and 32");
  end

  // A hardware set in the same cycle as a software write wins, so no
  // event is lost when software clears a flag just as it fires again.
  always_comb begin
    state_next = state_reg;
    if (wr_i) begin
      state_next.bits = wdata_i;
    end
    state_next.bits = (state_next.bits | set_i) & IMPL;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg.bits <= RESET & IMPL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value_o = state_reg.bits;

endmodule : irq_bit_bank
`default_nettype wire

//--- src/irq_flag4_enable0_regs.sv
// Fourth interrupt flag register and first interrupt enable register.
//
// What this block does
// - Audio left and right flags sit at bits 15 and 14, set on request.
// - Encoder B event bit 11, PWM B fault bit 10, PWM B event bit 9.
// - CAN transmit flag at bit 6; its request is masked when built without CAN.
// - DMA channel 7 done flag at bit 5, channel 6 at bit 4.
// - Checksum generator flag at bit 3, set once it requests.
// - Serial B error flag at bit 2, serial A error flag at bit 1.
// - Flag register bits 13-12, 8-7 and 0 always read as zero.
// - All implemented bits are read/write and clear to zero at reset.
// - Audio interrupts stay disabled when built without the audio unit.
// - Enable bit one permits its source's request, zero blocks it.
// - DMA channel 1 enable at bit 14, ADC done enable at bit 13.
// - Serial A transmit enable at bit 12, receive enable at bit 11.
// - SPI A event enable at bit 10, SPI A error enable at bit 9.
// - Timer three, two and one enables at bits 8, 7 and 3.
// - Compare channel 2 enable bit 6, capture channel 2 enable bit 5.
// - DMA channel 0 done enable sits at bit 4.
// - Compare channel 1 enable bit 2, capture channel 1 enable bit 1.
// - External pin 0 enable at bit 0 permits that pin's request.
// - Enable register bit 15 is unimplemented and reads as zero.
`timescale 1ns/10ps
`default_nettype none
module irq_flag4_enable0_regs #(
  parameter logic HAS_AUDIO = 1'b1,
  parameter logic HAS_CAN = 1'b1
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register port.
  input wire logic [irq_regs_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [irq_regs_pkg::DATA_W-1:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [irq_regs_pkg::DATA_W-1:0] REG_RDATA_O,
  // Request inputs of the flag_status_4 sources.
  input wire logic AUDIO_LEFT_REQ_I,
  input wire logic AUDIO_RIGHT_REQ_I,
  input wire logic ENCODER_B_EVENT_REQ_I,
  input wire logic PWM_B_FAULT_REQ_I,
  input wire logic PWM_B_EVENT_REQ_I,
  input wire logic CAN_TX_REQUEST_REQ_I,
  input wire logic DMA_CH7_DONE_REQ_I,
  input wire logic DMA_CH6_DONE_REQ_I,
  input wire logic CHECKSUM_GEN_REQ_I,
  input wire logic SERIAL_B_ERROR_REQ_I,
  input wire logic SERIAL_A_ERROR_REQ_I,
  // Enables of the flag_status_4 sources, held in another register.
  input wire logic [irq_regs_pkg::DATA_W-1:0] FLAG4_ENABLE_I,
  // Flags of the interrupt_enable_0 sources, held in another register.
  input wire logic [irq_regs_pkg::DATA_W-1:0] FLAG0_I,
  // Flag outputs.
  output logic AUDIO_LEFT_FLAG_O,
  output logic AUDIO_RIGHT_FLAG_O,
  output logic ENCODER_B_EVENT_FLAG_O,
  output logic PWM_B_FAULT_FLAG_O,
  output logic PWM_B_EVENT_FLAG_O,
  output logic CAN_TX_REQUEST_FLAG_O,
  output logic DMA_CH7_DONE_FLAG_O,
  output logic DMA_CH6_DONE_FLAG_O,
  output logic CHECKSUM_GEN_FLAG_O,
  output logic SERIAL_B_ERROR_FLAG_O,
  output logic SERIAL_A_ERROR_FLAG_O,
  // Enable outputs.
  output logic DMA_CH1_DONE_ENABLE_O,
  output logic ADC_DONE_ENABLE_O,
  output logic SERIAL_A_TX_ENABLE_O,
  output logic SERIAL_A_RX_ENABLE_O,
  output logic SPI_A_EVENT_ENABLE_O,
  output logic SPI_A_ERROR_ENABLE_O,
  output logic TIMER_THREE_ENABLE_O,
  output logic TIMER_TWO_ENABLE_O,
  output logic COMPARE_CH2_ENABLE_O,
  output logic CAPTURE_CH2_ENABLE_O,
  output logic DMA_CH0_DONE_ENABLE_O,
  output logic TIMER_ONE_ENABLE_O,
  output logic COMPARE_CH1_ENABLE_O,
  output logic CAPTURE_CH1_ENABLE_O,
  output logic EXT_PIN0_ENABLE_O,
  // Requests forwarded to the processor.
  output logic [irq_regs_pkg::DATA_W-1:0] FLAG4_REQ_O,
  output logic [irq_regs_pkg::DATA_W-1:0] ENABLE0_REQ_O
);
  import irq_regs_pkg::*;

  // ********************************************************************
  // Declarations
  // ********************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] req4;
    logic [DATA_W-1:0] req0;
  } top_type;

  top_type state_reg;
  top_type state_next;

  logic [DATA_W-1:0] flag4_set;
  logic [DATA_W-1:0] flag4_value;
  logic [DATA_W-1:0] enable0_value;
  logic [DATA_W-1:0] variant_mask;
  logic flag4_wr;
  logic enable0_wr;

  // ********************************************************************
  // Register port decode
  // ********************************************************************
  assign flag4_wr = REG_WR_I && (REG_ADDR_I == FLAG4_IDX);
  assign enable0_wr = REG_WR_I && (REG_ADDR_I == ENABLE0_IDX);

  // ********************************************************************
  // Hardware set inputs of flag_status_4
  // ********************************************************************
  // Sources set their flag whatever the matching enable says.
  always_comb begin
    flag4_set = '0;
    flag4_set[AUDIO_LEFT_BIT] = AUDIO_LEFT_REQ_I;
    flag4_set[AUDIO_RIGHT_BIT] = AUDIO_RIGHT_REQ_I;
    flag4_set[ENCODER_B_BIT] = ENCODER_B_EVENT_REQ_I;
    flag4_set[PWM_B_FAULT_BIT] = PWM_B_FAULT_REQ_I;
    flag4_set[PWM_B_EVENT_BIT] = PWM_B_EVENT_REQ_I;
    flag4_set[CAN_TX_BIT] = CAN_TX_REQUEST_REQ_I;
    flag4_set[DMA_CH7_BIT] = DMA_CH7_DONE_REQ_I;
    flag4_set[DMA_CH6_BIT] = DMA_CH6_DONE_REQ_I;
    flag4_set[CHECKSUM_GEN_BIT] = CHECKSUM_GEN_REQ_I;
    flag4_set[SERIAL_B_ERR_BIT] = SERIAL_B_ERROR_REQ_I;
    flag4_set[SERIAL_A_ERR_BIT] = SERIAL_A_ERROR_REQ_I;
  end

  // ********************************************************************
  // Register banks
  // ********************************************************************
  // The bank keeps what software writes, so writing one to a flag raises
  // a request exactly as the source would, and writing zero clears it.
  irq_bit_bank #(
    .WIDTH(DATA_W),
    .IMPL(FLAG4_IMPL),
    .RESET(FLAG4_RESET)
  ) u_flag4 (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .wr_i(flag4_wr),
    .wdata_i(REG_WDATA_I),
    .set_i(flag4_set),
    .value_o(flag4_value)
  );

  // Enables have no hardware setter; only software changes them.
  irq_bit_bank #(
    .WIDTH(DATA_W),
    .IMPL(ENABLE0_IMPL),
    .RESET(ENABLE0_RESET)
  ) u_enable0 (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .wr_i(enable0_wr),
    .wdata_i(REG_WDATA_I),
    .set_i('0),
    .value_o(enable0_value)
  );

  // ********************************************************************
  // Variant masking
  // ********************************************************************
  // On a build without the unit the flag still reads and writes, but it
  // can never reach the processor, so stray writes stay harmless.
  always_comb begin
    variant_mask = '1;
    if (!HAS_AUDIO) begin
      variant_mask[AUDIO_LEFT_BIT] = 1'b0;
      variant_mask[AUDIO_RIGHT_BIT] = 1'b0;
    end
    if (!HAS_CAN) begin
      variant_mask[CAN_TX_BIT] = 1'b0;
    end
  end

  // ********************************************************************
  // Next state: read data and forwarded requests
  // ********************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rdata = READ_IDLE;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        FLAG4_IDX: begin
          state_next.rdata = flag4_value;
        end
        ENABLE0_IDX: begin
          state_next.rdata = enable0_value;
        end
        default: begin
          state_next.rdata = READ_IDLE;
        end
      endcase
    end
    // A request goes out one cycle after both flag and enable are one.
    state_next.req4 = flag4_value & FLAG4_ENABLE_I & variant_mask;
    state_next.req0 = FLAG0_I & enable0_value;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg.rdata <= READ_IDLE;
      state_reg.req4 <= '0;
      state_reg.req0 <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign REG_RDATA_O = state_reg.rdata;
  assign FLAG4_REQ_O = state_reg.req4;
  assign ENABLE0_REQ_O = state_reg.req0;

  assign AUDIO_LEFT_FLAG_O = flag4_value[AUDIO_LEFT_BIT];
  assign AUDIO_RIGHT_FLAG_O = flag4_value[AUDIO_RIGHT_BIT];
  assign ENCODER_B_EVENT_FLAG_O = flag4_value[ENCODER_B_BIT];
  assign PWM_B_FAULT_FLAG_O = flag4_value[PWM_B_FAULT_BIT];
  assign PWM_B_EVENT_FLAG_O = flag4_value[PWM_B_EVENT_BIT];
  assign CAN_TX_REQUEST_FLAG_O = flag4_value[CAN_TX_BIT];
  assign DMA_CH7_DONE_FLAG_O = flag4_value[DMA_CH7_BIT];
  assign DMA_CH6_DONE_FLAG_O = flag4_value[DMA_CH6_BIT];
  assign CHECKSUM_GEN_FLAG_O = flag4_value[CHECKSUM_GEN_BIT];
  assign SERIAL_B_ERROR_FLAG_O = flag4_value[SERIAL_B_ERR_BIT];
  assign SERIAL_A_ERROR_FLAG_O = flag4_value[SERIAL_A_ERR_BIT];

  assign DMA_CH1_DONE_ENABLE_O = enable0_value[DMA_CH1_EN_BIT];
  assign ADC_DONE_ENABLE_O = enable0_value[ADC_EN_BIT];
  assign SERIAL_A_TX_ENABLE_O = enable0_value[SERIAL_A_TX_EN_BIT];
  assign SERIAL_A_RX_ENABLE_O = enable0_value[SERIAL_A_RX_EN_BIT];
  assign SPI_A_EVENT_ENABLE_O = enable0_value[SPI_A_EVENT_EN_BIT];
  assign SPI_A_ERROR_ENABLE_O = enable0_value[SPI_A_ERROR_EN_BIT];
  assign TIMER_THREE_ENABLE_O = enable0_value[TIMER_THREE_EN_BIT];
  assign TIMER_TWO_ENABLE_O = enable0_value[TIMER_TWO_EN_BIT];
  assign COMPARE_CH2_ENABLE_O = enable0_value[COMPARE_CH2_EN_BIT];
  assign CAPTURE_CH2_ENABLE_O = enable0_value[CAPTURE_CH2_EN_BIT];
  assign DMA_CH0_DONE_ENABLE_O = enable0_value[DMA_CH0_EN_BIT];
  assign TIMER_ONE_ENABLE_O = enable0_value[TIMER_ONE_EN_BIT];
  assign COMPARE_CH1_ENABLE_O = enable0_value[COMPARE_CH1_EN_BIT];
  assign CAPTURE_CH1_ENABLE_O = enable0_value[CAPTURE_CH1_EN_BIT];
  assign EXT_PIN0_ENABLE_O = enable0_value[EXT_PIN0_EN_BIT];

endmodule : irq_flag4_enable0_regs
`default_nettype wire

//--- bench/irq_regs_chk.sv
// Port assertions for the flag and enable register block.
`timescale 1ns/10ps
`default_nettype none
module irq_regs_chk (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic DMA_CH6_DONE_REQ_I,
  input wire logic DMA_CH6_DONE_FLAG_O,
  input wire logic SERIAL_A_ERROR_FLAG_O,
  input wire logic EXT_PIN0_ENABLE_O,
  input wire logic [15:0] FLAG4_ENABLE_I,
  input wire logic [15:0] FLAG0_I,
  input wire logic [15:0] FLAG4_REQ_O,
  input wire logic [15:0] ENABLE0_REQ_O
);
  import irq_regs_pkg::*;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  wire rd4 = REG_RD_I && REG_ADDR_I == FLAG4_IDX;
  wire rde = REG_RD_I && REG_ADDR_I == ENABLE0_IDX;
  wire wre = REG_WR_I && REG_ADDR_I == ENABLE0_IDX;
  property p_rd_idle; !REG_RD_I |=> REG_RDATA_O == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_f4_gap; rd4 |=> (REG_RDATA_O & 16'h3181) == 16'h0000; endproperty
  a_f4_gap: assert property (p_f4_gap)
    else $error("flag register gap bits not zero");
  property p_e0_top; rde |=> !REG_RDATA_O[15]; endproperty
  a_e0_top: assert property (p_e0_top)
    else $error("enable register top bit not zero");
  property p_set; DMA_CH6_DONE_REQ_I |=> DMA_CH6_DONE_FLAG_O; endproperty
  a_set: assert property (p_set)
    else $error("source did not set its flag");
  property p_sticky;
    SERIAL_A_ERROR_FLAG_O && !REG_WR_I |=> SERIAL_A_ERROR_FLAG_O;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a write");
  property p_ext_clr; wre && !REG_WDATA_I[0] |=> !EXT_PIN0_ENABLE_O; endproperty
  a_ext_clr: assert property (p_ext_clr)
    else $error("enable write of zero ignored");
  property p_fwd;
    DMA_CH6_DONE_FLAG_O && FLAG4_ENABLE_I[4] |=> FLAG4_REQ_O[4];
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("enabled flag not forwarded");
  property p_block; !FLAG4_ENABLE_I[4] |=> !FLAG4_REQ_O[4]; endproperty
  a_block: assert property (p_block)
    else $error("disabled flag forwarded");
  property p_e0_fwd; FLAG0_I[0] && EXT_PIN0_ENABLE_O |=> ENABLE0_REQ_O[0];
  endproperty
  a_e0_fwd: assert property (p_e0_fwd)
    else $error("pin request not forwarded");
  c_rd4: cover property (rd4);
  c_fwd: cover property (FLAG4_REQ_O[4]);
  c_e0: cover property (ENABLE0_REQ_O[0]);
endmodule : irq_regs_chk
`default_nettype wire

//--- bench/irq_src_model.sv
// Behavioural model of the peripheral sources that raise requests.
`timescale 1ns/10ps
`default_nettype none
module irq_src_model (
  input wire logic [15:0] fire_i,
  output logic [15:0] req_o
);
  // A source holds its request only while the bench fires it.
  assign req_o = fire_i;
endmodule : irq_src_model
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the flag and enable register block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import irq_regs_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic REG_WR_I = 1'b0;
  logic REG_RD_I = 1'b0;
  logic [3:0] REG_ADDR_I = 4'h0;
  logic [15:0] REG_WDATA_I = 16'h0000;
  logic [15:0] FLAG4_ENABLE_I = 16'h0000;
  logic [15:0] FLAG0_I = 16'h0000;
  logic [15:0] fire = 16'h0000;
  logic [15:0] one, a, b, c;
  logic [31:0] seed = 32'h5d5f_ceee;
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;
  int fails = 0;
  int total_checks = 0;
  wire [15:0] rq, fl, en, rdata, f4req, e0req;
  irq_src_model irq_src_model_inst (.fire_i(fire), .req_o(rq));
  irq_flag4_enable0_regs irq_flag4_enable0_regs_inst (
    .CLK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
    .REG_RDATA_O(rdata), .FLAG4_ENABLE_I, .FLAG0_I,
    .AUDIO_LEFT_REQ_I(rq[15]), .AUDIO_RIGHT_REQ_I(rq[14]),
    .ENCODER_B_EVENT_REQ_I(rq[11]), .PWM_B_FAULT_REQ_I(rq[10]),
    .PWM_B_EVENT_REQ_I(rq[9]), .CAN_TX_REQUEST_REQ_I(rq[6]),
    .DMA_CH7_DONE_REQ_I(rq[5]), .DMA_CH6_DONE_REQ_I(rq[4]),
    .CHECKSUM_GEN_REQ_I(rq[3]), .SERIAL_B_ERROR_REQ_I(rq[2]),
    .SERIAL_A_ERROR_REQ_I(rq[1]),
    .AUDIO_LEFT_FLAG_O(fl[15]), .AUDIO_RIGHT_FLAG_O(fl[14]),
    .ENCODER_B_EVENT_FLAG_O(fl[11]), .PWM_B_FAULT_FLAG_O(fl[10]),
    .PWM_B_EVENT_FLAG_O(fl[9]), .CAN_TX_REQUEST_FLAG_O(fl[6]),
    .DMA_CH7_DONE_FLAG_O(fl[5]), .DMA_CH6_DONE_FLAG_O(fl[4]),
    .CHECKSUM_GEN_FLAG_O(fl[3]), .SERIAL_B_ERROR_FLAG_O(fl[2]),
    .SERIAL_A_ERROR_FLAG_O(fl[1]),
    .DMA_CH1_DONE_ENABLE_O(en[14]), .ADC_DONE_ENABLE_O(en[13]),
    .SERIAL_A_TX_ENABLE_O(en[12]), .SERIAL_A_RX_ENABLE_O(en[11]),
    .SPI_A_EVENT_ENABLE_O(en[10]), .SPI_A_ERROR_ENABLE_O(en[9]),
    .TIMER_THREE_ENABLE_O(en[8]), .TIMER_TWO_ENABLE_O(en[7]),
    .COMPARE_CH2_ENABLE_O(en[6]), .CAPTURE_CH2_ENABLE_O(en[5]),
    .DMA_CH0_DONE_ENABLE_O(en[4]), .TIMER_ONE_ENABLE_O(en[3]),
    .COMPARE_CH1_ENABLE_O(en[2]), .CAPTURE_CH1_ENABLE_O(en[1]),
    .EXT_PIN0_ENABLE_O(en[0]), .FLAG4_REQ_O(f4req), .ENABLE0_REQ_O(e0req));
  // Positions with no output read as zero, so whole words can be compared.
  assign fl[13:12] = 2'b00;
  assign fl[8:7] = 2'b00;
  assign fl[0] = 1'b0;
  assign en[15] = 1'b0;
  initial forever #2.5 CLK_I = ~CLK_I;
  task automatic chk(input string nm, input logic [15:0] seen, want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic bus(input logic w, r, input logic [3:0] ad,
                     input logic [15:0] d);
    REG_WR_I <= w;
    REG_RD_I <= r;
    REG_ADDR_I <= ad;
    REG_WDATA_I <= d;
    @(posedge CLK_I);
  endtask : bus
  task automatic rd(input logic [3:0] ad, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, ad, 16'h0000);
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(posedge CLK_I) begin
    if (rd_seen) chk("read data", rdata, exp_q.pop_front());
    rd_seen <= REG_RD_I;
  end
  initial begin
    repeat (5000) @(posedge CLK_I);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_I);
    rd(FLAG4_IDX, 16'h0000);
    rd(ENABLE0_IDX, 16'h0000);
    bus(1'b1, 1'b0, FLAG4_IDX, 16'hffff);
    bus(1'b1, 1'b0, ENABLE0_IDX, 16'hffff);
    bus(1'b1, 1'b0, 4'h5, 16'hffff);
    rd(FLAG4_IDX, 16'hce7e);
    rd(ENABLE0_IDX, 16'h7fff);
    rd(4'h5, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      one = 16'h0001 << i;
      fire <= one;
      // The source fires in the clearing write's cycle, so set must win.
      bus(1'b1, 1'b0, FLAG4_IDX, 16'h0000);
      fire <= 16'h0000;
      rd(FLAG4_IDX, one & 16'hce7e);
      chk("flags", fl & 16'hce7e, one & 16'hce7e);
      bus(1'b1, 1'b0, ENABLE0_IDX, one);
      rd(ENABLE0_IDX, one & 16'h7fff);
      chk("enables", en & 16'h7fff, one & 16'h7fff);
    end
    for (int k = 0; k < 24; k++) begin
      repeat (17) seed = lfsr(seed);
      a = seed[15:0];
      b = seed[31:16];
      c = seed[23:8];
      FLAG4_ENABLE_I <= c;
      FLAG0_I <= c;
      bus(1'b1, 1'b0, ENABLE0_IDX, a);
      bus(1'b1, 1'b0, FLAG4_IDX, b);
      rd(FLAG4_IDX, b & 16'hce7e);
      rd(ENABLE0_IDX, a & 16'h7fff);
      chk("flag4 req", f4req, b & c & 16'hce7e);
      chk("enable0 req", e0req, a & c & 16'h7fff);
    end
    // A reset in mid-run must clear what software and sources have set.
    fire <= 16'hffff;
    bus(1'b1, 1'b0, FLAG4_IDX, 16'hffff);
    fire <= 16'h0000;
    RST_B_I <= 1'b0;
    repeat (2) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    RST_B_I <= 1'b1;
    chk("flags after reset", fl, FLAG4_RESET);
    chk("enables after reset", en, ENABLE0_RESET);
    chk("requests after reset", f4req | e0req, 16'h0000);
    rd(FLAG4_IDX, FLAG4_RESET);
    rd(ENABLE0_IDX, ENABLE0_RESET);
    repeat (2) bus(1'b0, 1'b0, 4'h0, 16'h0000);
    give_verdict();
  end
endmodule : testbench
bind irq_flag4_enable0_regs irq_regs_chk irq_regs_chk_inst (
  .CLK_I, .RST_B_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I,
  .REG_RDATA_O, .DMA_CH6_DONE_REQ_I, .DMA_CH6_DONE_FLAG_O,
  .SERIAL_A_ERROR_FLAG_O, .EXT_PIN0_ENABLE_O, .FLAG4_ENABLE_I, .FLAG0_I,
  .FLAG4_REQ_O, .ENABLE0_REQ_O);
`default_nettype wire
